/* File: design/aux_adc_regs.vh */
`ifndef AUX_ADC_REGS_VH
`define AUX_ADC_REGS_VH

// command word layout: address nibble on top, mode fields below
`define CMD_BITS           16
`define CMD_COUNT_W        5
`define CMD_ADDR_MSB       15
`define CMD_ADDR_LSB       12
`define AUX_MODE_ADDR      4'h3

// mode register fields
`define MODE_W             11
`define MODE_RESET         11'h000
`define START_BIT          0
`define REF_BIT            1
`define MUX_LSB            2
`define MUX_MSB            3
`define AVG_LSB            4
`define AVG_MSB            6
`define DIV_LSB            7
`define DIV_MSB            9
`define OUTEN_BIT          10

// conversion sequence
`define EDGES_PER_CONV     12
`define EDGE_SAMPLE        4'h0
`define EDGE_LOAD          4'hB
`define AVG_MAX_CODE       3'h5
`define HOLD_BITS          6

// timing kept by the host
`define CLK_PERIOD_PS      25000
`define CS_HIGH_MIN_PS     80000
`define CS_HIGH_MIN_CYC    ((`CS_HIGH_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CLK_WAKE_PS        7200000
`define CLK_WAKE_CYC       ((`CLK_WAKE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CONV_CLK_MAX_HZ    4000000

`endif

/* File: design/aux_adc_serial_control.v */
`timescale 1ns/10ps
`include "aux_adc_regs.vh"

// Overview of operation
// - sample serial input MSB first on rising clock
// - latch sixteen-bit word on chip select rise
// - serial clock may idle high or low
// - stopped clock keeps all state frozen
// - start bit one begins a conversion
// - start bit self-clears after full conversion
// - start writes during conversion are ignored
// - reference select zero bandgap, one supply
// - two-bit input select steers four-way mux
// - averaging code picks 1 to 32 conversions
// - twelve conversion clock edges per conversion
// - total time 12 x averages x divisor
// - output mode bit gates result onto output
// - output busy high, low when ready
// - result out MSB first on falling clock
// - output released while chip select high
// - unread result blocks new conversion starts
module aux_adc_serial_control #(
   parameter RES_W = 10
) (
   input  wire             CLK,
   input  wire             RST_N,
   input  wire             CE,
   input  wire             CS_N,
   input  wire             SCLK,
   input  wire             DIN,
   output reg              DOUT,
   output reg              DOUT_OE,
   input  wire             COMP,
   output reg              SAMPLE,
   output reg  [RES_W-1:0] SAR_CODE,
   output reg              REF_SEL,
   output reg  [1:0]       MUX_SEL
);

   localparam ACC_W  = RES_W + 5;
   localparam SH_W   = RES_W + `HOLD_BITS;
   localparam ST_IDLE = 2'h0;
   localparam ST_CONV = 2'h1;
   localparam ST_DONE = 2'h2;

   // terminal count of the conversion clock divider
   function [6:0] div_tc;
      input [2:0] code;
      reg   [7:0] tmp;
      begin
         tmp    = (8'h01 << code) - 8'h01;
         div_tc = tmp[6:0];
      end
   endfunction

   // averaging shift; codes above five saturate at 32 conversions
   function [2:0] avg_shift;
      input [2:0] code;
      begin
         avg_shift = (code > `AVG_MAX_CODE) ? `AVG_MAX_CODE : code;
      end
   endfunction

   // index of the last sub-conversion of an averaged run
   function [5:0] avg_last;
      input [2:0] code;
      reg   [6:0] tmp;
      begin
         tmp      = (7'h01 << avg_shift(code)) - 7'h01;
         avg_last = tmp[5:0];
      end
   endfunction

   // one successive-approximation step: resolve bit under test, try the next one
   function [RES_W-1:0] sar_step;
      input [RES_W-1:0] code;
      input [3:0]       e;
      input             comp;
      integer           i;
      begin
         sar_step = code;
         for (i = 0; i < RES_W; i = i + 1) begin
            if (i == RES_W - e)
               sar_step[i] = comp;
            if (i == RES_W - 1 - e)
               sar_step[i] = 1'b1;
         end
      end
   endfunction

   reg  [1:0]             state_r;
   reg                    sclk_q_r;
   reg                    cs_q_r;
   reg  [`CMD_BITS-1:0]   shift_in_r;
   reg  [`CMD_COUNT_W-1:0] bit_cnt_r;
   reg  [`MODE_W-1:0]     mode_r;
   reg                    dis_r;
   reg                    read_frame_r;
   reg  [SH_W-1:0]        dout_sh_r;
   reg  [RES_W-1:0]       result_r;
   reg  [2:0]             snap_avg_r;
   reg  [2:0]             snap_div_r;
   reg  [6:0]             div_cnt_r;
   reg  [3:0]             edge_r;
   reg  [5:0]             sub_r;
   reg  [ACC_W-1:0]       acc_r;
   reg                    dout_nxt;
   reg                    dout_oe_nxt;

   wire        sclk_rise  = ~CS_N & SCLK & ~sclk_q_r;
   wire        sclk_fall  = ~CS_N & ~SCLK & sclk_q_r;
   wire        cs_fall    = cs_q_r & ~CS_N;
   wire        cs_rise    = ~cs_q_r & CS_N;
   wire        cmd_valid  = cs_rise & (bit_cnt_r == `CMD_BITS);
   wire        wr_mode    = cmd_valid &
                            (shift_in_r[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `AUX_MODE_ADDR);
   wire        new_start  = shift_in_r[`START_BIT];
   // a finished read frame frees the output register, so a start in it is taken at once
   wire        read_done  = (state_r == ST_DONE) & read_frame_r & cs_rise;
   wire        slot_free  = (state_r == ST_IDLE) | read_done;
   wire        start_conv = wr_mode & new_start & slot_free;
   wire        tick       = (state_r == ST_CONV) & (div_cnt_r == div_tc(snap_div_r));
   wire        last_edge  = tick & (edge_r == `EDGE_LOAD);
   wire        last_sub   = sub_r == avg_last(snap_avg_r);
   wire        conv_end   = last_edge & last_sub;
   wire        load_out   = cs_fall & (state_r == ST_DONE) & mode_r[`OUTEN_BIT] & ~dis_r;
   // wide enough to sum 32 full-scale codes without wrap
   wire [ACC_W-1:0] acc_sum = acc_r + {{(ACC_W-RES_W){1'b0}}, SAR_CODE};
   wire [ACC_W-1:0] acc_avg = acc_sum >> avg_shift(snap_avg_r);

   // serial pins are sampled in the system clock domain; CE low freezes everything
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sclk_q_r   <= 1'b0;
         cs_q_r     <= 1'b1;
         shift_in_r <= {`CMD_BITS{1'b0}};
         bit_cnt_r  <= {`CMD_COUNT_W{1'b0}};
      end else if (CE) begin
         sclk_q_r <= SCLK;
         cs_q_r   <= CS_N;
         if (sclk_rise) begin
            shift_in_r <= {shift_in_r[`CMD_BITS-2:0], DIN};
            if (cs_fall)
               bit_cnt_r <= 5'h01;
            else if (bit_cnt_r != `CMD_BITS)
               bit_cnt_r <= bit_cnt_r + 5'h01;
         end else if (cs_fall) begin
            bit_cnt_r <= 5'h00;
         end
      end
   end

   // mode register and result hand-off
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_r       <= `MODE_RESET;
         state_r      <= ST_IDLE;
         dis_r        <= 1'b0;
         read_frame_r <= 1'b0;
      end else if (CE) begin
         if (cs_fall)
            read_frame_r <= (state_r == ST_DONE) & mode_r[`OUTEN_BIT] & ~dis_r;
         else if (cs_rise)
            read_frame_r <= 1'b0;
         if (wr_mode) begin
            if (state_r == ST_CONV)
               mode_r <= {shift_in_r[`MODE_W-1:1], 1'b1};
            else
               mode_r <= shift_in_r[`MODE_W-1:0];
         end
         case (state_r)
            ST_IDLE: begin
               if (start_conv)
                  state_r <= ST_CONV;
            end
            ST_CONV: begin
               if (conv_end) begin
                  state_r              <= ST_DONE;
                  mode_r[`START_BIT]   <= 1'b0;
               end
            end
            ST_DONE: begin
               if (read_done) begin
                  state_r <= start_conv ? ST_CONV : ST_IDLE;
                  dis_r   <= 1'b0;
               end else if (wr_mode & new_start) begin
                  dis_r <= 1'b1;
               end else if (wr_mode) begin
                  // start bit written zero drops the stale result and recovers
                  state_r <= ST_IDLE;
                  dis_r   <= 1'b0;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // conversion sequencer on divided clock ticks
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         snap_avg_r <= 3'h0;
         snap_div_r <= 3'h0;
         REF_SEL    <= 1'b0;
         MUX_SEL    <= 2'h0;
         div_cnt_r  <= 7'h00;
         edge_r     <= 4'h0;
         sub_r      <= 6'h00;
         acc_r      <= {ACC_W{1'b0}};
         SAR_CODE   <= {RES_W{1'b0}};
         result_r   <= {RES_W{1'b0}};
         SAMPLE     <= 1'b0;
      end else if (CE) begin
         SAMPLE <= tick & (edge_r == `EDGE_SAMPLE);
         if (start_conv) begin
            // settings are captured once so a mid-conversion write cannot skew averaging
            REF_SEL    <= shift_in_r[`REF_BIT];
            MUX_SEL    <= shift_in_r[`MUX_MSB:`MUX_LSB];
            snap_avg_r <= shift_in_r[`AVG_MSB:`AVG_LSB];
            snap_div_r <= shift_in_r[`DIV_MSB:`DIV_LSB];
            div_cnt_r  <= 7'h00;
            edge_r     <= 4'h0;
            sub_r      <= 6'h00;
            acc_r      <= {ACC_W{1'b0}};
         end else if (state_r == ST_CONV) begin
            if (tick)
               div_cnt_r <= 7'h00;
            else
               div_cnt_r <= div_cnt_r + 7'h01;
            if (tick) begin
               if (edge_r == `EDGE_SAMPLE) begin
                  SAR_CODE <= {1'b1, {(RES_W-1){1'b0}}};
                  edge_r   <= edge_r + 4'h1;
               end else if (edge_r == `EDGE_LOAD) begin
                  edge_r <= 4'h0;
                  acc_r  <= acc_sum;
                  sub_r  <= sub_r + 6'h01;
                  if (last_sub)
                     result_r <= acc_avg[RES_W-1:0];
               end else begin
                  SAR_CODE <= sar_step(SAR_CODE, edge_r, COMP);
                  edge_r   <= edge_r + 4'h1;
               end
            end
         end
      end
   end

   // result shifter, loaded when a read frame opens
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         dout_sh_r <= {SH_W{1'b0}};
      end else if (CE) begin
         if (load_out)
            dout_sh_r <= {result_r, {`HOLD_BITS{result_r[0]}}};
         // a fall before the frame's first rise is an idle-high clock leaving
         // rest; shifting there would drop the msb before the host sees it
         else if (sclk_fall & read_frame_r & (bit_cnt_r != {`CMD_COUNT_W{1'b0}}))
            dout_sh_r <= {dout_sh_r[SH_W-2:0], result_r[0]};
      end
   end

   // pin value and enable; the pin is released whenever chip select is high
   always @* begin
      dout_nxt    = 1'b0;
      dout_oe_nxt = 1'b0;
      if (CS_N) begin
         dout_oe_nxt = 1'b0;
      end else if (state_r == ST_CONV) begin
         dout_oe_nxt = 1'b1;
         dout_nxt    = 1'b1;
      end else if ((state_r == ST_DONE) & ~dis_r) begin
         dout_oe_nxt = 1'b1;
         if (load_out)
            dout_nxt = result_r[RES_W-1];
         else if (read_frame_r)
            dout_nxt = dout_sh_r[SH_W-1];
         else
            dout_nxt = 1'b0;
      end
   end

   // pin driver flops; a disabled output stays released until recovery
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         DOUT    <= 1'b0;
         DOUT_OE <= 1'b0;
      end else if (CE) begin
         DOUT    <= dout_nxt;
         DOUT_OE <= dout_oe_nxt;
      end
   end

endmodule // aux_adc_serial_control

/* File: dv/aux_adc_host_model.sv */
`timescale 1ns/10ps
module aux_adc_host_model (
   input  wire CLK,
   input  wire DOUT,
   input  wire DOUT_OE,
   output reg  CS_N,
   output reg  SCLK,
   output reg  DIN
);
   initial begin
      CS_N = 1'b1;
      SCLK = 1'b0;
      DIN  = 1'b0;
   end
   // called just after a falling clock; a released output reads back as unknown
   task automatic xfer(input [15:0] w, input integer nb, input idle, output [15:0] r);
      integer i;
      r = 16'h0000;
      CS_N = 1'b0;
      repeat (2) @(negedge CLK); // clock still rests at its idle level here
      for (i = 0; i < nb; i = i + 1) begin
         SCLK = 1'b0;
         DIN = w[15-i];
         repeat (2) @(negedge CLK);
         SCLK = 1'b1;
         repeat (2) @(negedge CLK);
         r[15-i] = DOUT_OE ? DOUT : 1'bx;
      end
      SCLK = idle;
      repeat (2) @(negedge CLK);
      CS_N = 1'b1;
      DIN = ~DIN;
      repeat (4) @(negedge CLK);
   endtask
   task automatic wait_ready(output integer n);
      n = 0;
      CS_N = 1'b0;
      while (!(DOUT_OE === 1'b1 && DOUT === 1'b0) && n < 60000) begin
         @(negedge CLK);
         n = n + 1;
      end
      CS_N = 1'b1;
      repeat (4) @(negedge CLK);
   endtask
endmodule // aux_adc_host_model

/* File: dv/aux_adc_serial_control_asserts.sv */
`timescale 1ns/10ps
module aux_adc_serial_control_asserts #(
   parameter RES_W = 10
) (
   input wire             CLK,
   input wire             RST_N,
   input wire             CE,
   input wire             CS_N,
   input wire             DOUT,
   input wire             DOUT_OE,
   input wire             SAMPLE,
   input wire [RES_W-1:0] SAR_CODE,
   input wire             REF_SEL,
   input wire [1:0]       MUX_SEL
);
   reg [7:0] gap_r;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // enabled cycles since the last sample pulse, saturating
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         gap_r <= 8'hFF;
      else if (CE && SAMPLE)
         gap_r <= 8'h00;
      else if (CE && gap_r != 8'hFF)
         gap_r <= gap_r + 8'h01;
   end
   a_oe_cs_high: assert property (CS_N && $past(CS_N) && CE |=> !DOUT_OE)
      else $error("output driven with chip select high");
   a_oe_needs_cs: assert property (DOUT_OE && $past(CE) |-> !$past(CS_N))
      else $error("output driven without chip select");
   a_ce_freeze: assert property (!CE |=> $stable({DOUT, DOUT_OE, SAMPLE, SAR_CODE}))
      else $error("state moved while clock stopped");
   a_sample_once: assert property (SAMPLE && CE |=> !SAMPLE)
      else $error("sample pulse too long");
   a_sample_gap: assert property ($rose(SAMPLE) |-> gap_r >= 8'h0B)
      else $error("sample pulses closer than twelve cycles");
   a_sel_hold: assert property (!CS_N && DOUT_OE && DOUT && $past(DOUT_OE && DOUT)
      |-> $stable({REF_SEL, MUX_SEL})) else $error("selection moved while busy");
   a_sel_at_start: assert property ($changed({REF_SEL, MUX_SEL}) |-> $past(CS_N) && $past(CE))
      else $error("selection moved outside a command");
   a_busy_flag: assert property (SAMPLE && !CS_N && !$past(CS_N) && !$past(CS_N, 2)
      |-> DOUT_OE && DOUT) else $error("busy flag missing");
   cover property (SAMPLE && !CS_N);
   cover property (DOUT_OE && !DOUT);
   cover property ($fell(DOUT_OE));
endmodule // aux_adc_serial_control_asserts

/* File: dv/aux_adc_serial_control_tb_top.sv */
`timescale 1ns/10ps
`include "aux_adc_regs.vh"
module aux_adc_serial_control_tb_top;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         ce = 1'b1;
   wire        cs_n, sclk, din, dout, dout_oe, comp, sample, ref_sel;
   wire [9:0]  sar_code;
   wire [1:0]  mux_sel;
   reg  [9:0]  vin [0:7];
   reg  [15:0] rd;
   integer     n, i;
   integer     failures = 0;
   integer     n_checks = 0;
   always #12.5 clk = ~clk;
   // ideal comparator: a trial bit stays while the trial code is not above the input
   assign comp = (sar_code <= vin[{ref_sel, mux_sel}]);
   aux_adc_serial_control aux_adc_serial_control_inst (.CLK(clk), .RST_N(rst_n), .CE(ce),
      .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe), .COMP(comp),
      .SAMPLE(sample), .SAR_CODE(sar_code), .REF_SEL(ref_sel), .MUX_SEL(mux_sel));
   aux_adc_host_model aux_adc_host_model_inst (.CLK(clk), .DOUT(dout), .DOUT_OE(dout_oe),
      .CS_N(cs_n), .SCLK(sclk), .DIN(din));
   function [15:0] cmd(input oe, input [2:0] dv, input [2:0] av, input [2:0] s, input st);
      cmd = {`AUX_MODE_ADDR, 1'b0, oe, dv, av, s[1:0], s[2], st};
   endfunction
   task chk(input [95:0] nm, input [15:0] e, input [15:0] g);
      n_checks = n_checks + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input [15:0] c);
      aux_adc_host_model_inst.xfer(c, 16, 1'b0, rd);
   endtask
   task rd_check(input [2:0] s);
      wr(16'hFFFF);
      chk("result", {vin[s], {6{vin[s][0]}}}, rd);
   endtask
   // t counts from the end of the command frame; gap stops the clock meanwhile
   task t_time(input [15:0] c, input integer t, input integer gap, input idle);
      aux_adc_host_model_inst.xfer(c, 16, idle, rd);
      ce = (gap == 0);
      repeat (gap) @(negedge clk);
      ce = 1'b1;
      aux_adc_host_model_inst.wait_ready(n);
      n_checks = n_checks + 1;
      if (n < t - 2 || n > t + 1) begin
         failures = failures + 1;
         $display("MISMATCH conversion_time expected %0d seen %0d", t, n);
      end
      wr(cmd(0, 3'h0, 3'h0, 3'h0, 1'b0));
   endtask
   task t_reset;
      chk("dout_oe", 16'h0000, {15'h0000, dout_oe});
      chk("ref_mux", 16'h0000, {13'h0000, ref_sel, mux_sel});
   endtask
   task t_avg;
      for (i = 0; i < 8; i = i + 1)
         t_time(cmd(0, 3'h4, i[2:0], 3'h0, 1'b1), 192 * (1 << ((i > 5) ? 5 : i)), 0, 1'b0);
   endtask
   // fast divider codes exceed the conversion clock limit, only to time the table
   task t_div;
      for (i = 0; i < 8; i = i + 1)
         t_time(cmd(0, i[2:0], 3'h0, 3'h0, 1'b1), 12 * (1 << i), 0, 1'b0);
   endtask
   task t_read;
      for (i = 0; i < 8; i = i + 1) begin
         // odd passes leave the serial clock resting high for the read
         aux_adc_host_model_inst.xfer(cmd(1, 3'h4, 3'h0, i[2:0], 1'b1), 16, i[0], rd);
         repeat (220) @(negedge clk);
         rd_check(i[2:0]);
      end
   endtask
   task t_ignore;
      wr(cmd(1, 3'h4, 3'h3, 3'h1, 1'b1));
      wr(cmd(1, 3'h0, 3'h0, 3'h3, 1'b0));
      repeat (1600) @(negedge clk);
      rd_check(3'h1);
   endtask
   task t_block;
      wr(cmd(0, 3'h4, 3'h0, 3'h2, 1'b1));
      repeat (220) @(negedge clk);
      wr(cmd(0, 3'h4, 3'h0, 3'h2, 1'b1));
      aux_adc_host_model_inst.xfer(16'h0000, 1, 1'b0, rd);
      chk("disabled", {1'bx, 15'h0000}, rd);
      wr(cmd(0, 3'h0, 3'h0, 3'h0, 1'b0));
      wr(cmd(1, 3'h4, 3'h0, 3'h2, 1'b1));
      repeat (220) @(negedge clk);
      rd_check(3'h2);
   endtask
   task t_refuse;
      aux_adc_host_model_inst.xfer(cmd(0, 3'h4, 3'h0, 3'h7, 1'b1), 15, 1'b0, rd);
      chk("short_frame", 16'h0002, {13'h0000, ref_sel, mux_sel});
      wr(cmd(0, 3'h4, 3'h0, 3'h7, 1'b1) ^ 16'h7000);
      chk("other_addr", 16'h0002, {13'h0000, ref_sel, mux_sel});
   endtask
   // clock stopped while idle, then the settle wait before the next start
   task t_stop;
      ce = 1'b0;
      repeat (50) @(negedge clk);
      ce = 1'b1;
      chk("ref_mux_held", 16'h0002, {13'h0000, ref_sel, mux_sel});
      repeat (`CLK_WAKE_CYC) @(negedge clk);
      t_time(cmd(0, 3'h4, 3'h0, 3'h1, 1'b1), 192, 50, 1'b1);
   endtask
   task finish_test;
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      for (i = 0; i < 8; i = i + 1)
         vin[i] = 10'h2A5 ^ (i[9:0] * 10'h0C7);
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      t_reset;
      t_avg;
      t_div;
      t_read;
      t_ignore;
      t_block;
      t_refuse;
      t_stop;
      finish_test;
   end
   initial begin
      repeat (80000) @(posedge clk);
      failures = failures + 1;
      finish_test;
   end
endmodule // aux_adc_serial_control_tb_top
bind aux_adc_serial_control aux_adc_serial_control_asserts #(.RES_W(RES_W))
   aux_adc_serial_control_asserts_inst (.CLK(CLK), .RST_N(RST_N), .CE(CE), .CS_N(CS_N),
   .DOUT(DOUT), .DOUT_OE(DOUT_OE), .SAMPLE(SAMPLE), .SAR_CODE(SAR_CODE), .REF_SEL(REF_SEL),
   .MUX_SEL(MUX_SEL));
